/* verilog/pmcs_pkg.sv */
// Purpose: shared constants and types of the power mode and clock select block
// Assumes: 32-bit AXI4-Lite register access, one-hot clock source codes
// Notes: register offsets are byte addresses
package pmcs_pkg;
	localparam int PMCS_ADDR_W = 4;
	localparam logic [3:0] PMCS_OFS_OSC_CTL = 4'h0;
	localparam logic [3:0] PMCS_OFS_STATUS = 4'h4;
	localparam logic [3:0] PMCS_OFS_LPT_CTL = 4'h8;
	// field positions
	localparam int PMCS_BIT_IDLE = 7;
	localparam int PMCS_SEL_LSB = 0;
	localparam int PMCS_SEL_W = 2;
	localparam int PMCS_IFRQ_LSB = 4;
	localparam int PMCS_IFRQ_W = 3;
	localparam int PMCS_BIT_SEC_OSC_EN = 3;
	localparam int PMCS_BIT_SEC_ACTIVE = 6;
	localparam int PMCS_ST_SEC_ACT = 0;
	localparam int PMCS_ST_PRI_DONE = 1;
	localparam int PMCS_ST_SRC_LSB = 2;
	localparam int PMCS_ST_MODE_LSB = 5;
	// clock source select codes
	localparam logic [1:0] PMCS_SEL_PRI = 2'h0;
	localparam logic [1:0] PMCS_SEL_SEC = 2'h1;
	localparam logic [1:0] PMCS_SEL_RESET = 2'h0;
	// one-hot source codes: bit0 primary, bit1 secondary, bit2 internal
	typedef logic [2:0] pmcs_src_t;
	localparam pmcs_src_t PMCS_SRC_NONE = 3'h0;
	localparam pmcs_src_t PMCS_SRC_PRI = 3'h1;
	localparam pmcs_src_t PMCS_SRC_SEC = 3'h2;
	localparam pmcs_src_t PMCS_SRC_INT = 3'h4;
	localparam pmcs_src_t PMCS_SRC_RESET = 3'h1;
	// internal oscillator taps
	localparam logic [2:0] PMCS_IFRQ_SLOW = 3'h0;
	localparam logic [2:0] PMCS_IFRQ_FAST = 3'h7;
	localparam logic [2:0] PMCS_IFRQ_RESET = 3'h0;
	localparam logic [2:0] PMCS_TAP_SLOW = 3'h1;
	localparam logic [2:0] PMCS_TAP_POST = 3'h2;
	localparam logic [2:0] PMCS_TAP_FAST = 3'h4;
	// break-before-make gap count of the source switch; select stays zero for this many aclk cycles plus one
	localparam int PMCS_GAP_CYCLES = 2;
	localparam logic [1:0] PMCS_RESP_OKAY = 2'h0;
	localparam logic [1:0] PMCS_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		PMCS_ACTIVE = 3'h1,
		PMCS_IDLE = 3'h2,
		PMCS_SLEEP = 3'h4
	} pmcs_mode_t;
endpackage : pmcs_pkg

/* verilog/pmcs_glitch_mux.sv */
// Purpose: break-before-make sequencer for the one-hot clock source select
// Assumes: req is a one-cycle pulse taken only while busy is low
// Notes: select output drops to zero for gap plus one cycles between two sources
`timescale 1ns/1ps
`default_nettype none
module pmcs_glitch_mux
	import pmcs_pkg::*;
#(
	parameter int N = 3,
	parameter int GAP = PMCS_GAP_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req,
	input wire logic [N-1:0] req_sel,
	output logic [N-1:0] sel_out,
	output logic busy,
	output logic done
);
	localparam int CW = $clog2(GAP + 1);

	typedef struct packed {
		logic [N-1:0] sel;
		logic [N-1:0] pend;
		logic [CW-1:0] cnt;
		logic busy;
		logic done;
	} pmcs_mux_state_t;

	pmcs_mux_state_t s;
	pmcs_mux_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (s.busy) begin
			if (s.cnt != '0) begin
				next_s.cnt = s.cnt - 1'b1;
			end else begin
				next_s.sel = s.pend;
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end else if (req) begin
			// old source released first, so no runt pulse can form
			next_s.sel = '0;
			next_s.pend = req_sel;
			next_s.cnt = CW'(GAP);
			next_s.busy = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s.sel <= N'(PMCS_SRC_RESET);
			s.pend <= '0;
			s.cnt <= '0;
			s.busy <= 1'b0;
			s.done <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign sel_out = s.sel;
	assign busy = s.busy;
	assign done = s.done;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_mux_onehot: assert property ($onehot0(s.sel))
		else $error("more than one clock source selected");
	chk_mux_break: assert property (
		($past(s.sel) != '0 && s.sel != $past(s.sel)) |-> s.sel == '0)
		else $error("source changed without a dead gap");
endmodule : pmcs_glitch_mux
`default_nettype wire

/* verilog/pmcs_top.sv */
// Purpose: power-managed mode and system clock source selection
// Assumes: oscillator status inputs synchronous to aclk, halt and wake are pulses
// Notes: clock enables are combinational from registered state and the secondary_running input
// Notes on behaviour
// - two-bit select picks primary, secondary or internal clock source
// - modes start by software writing the control register: idle bit 7, select 1:0
// - a new select switches source at once when that source is running
// - idle or sleep is entered only by the halt instruction
// - idle bit is sampled when halt executes
// - idle bit 0 at halt gives sleep: all clocks stopped
// - run modes clock cpu and peripherals: 00 primary, 01 secondary, 1x internal
// - idle bit 1 at halt stops cpu, peripherals stay clocked
// - select 01: move to secondary, stop primary, set active flag, clear start flag
// - secondary oscillator disabled means select 01 does not enter secondary run
// - secondary enabled but not running: clocks withheld until it runs
// - secondary to primary keeps secondary clocking until primary is ready
// - finished switch to primary clears active flag and sets start flag
// - wake-up leaves idle bit, select and secondary oscillator unchanged
// - internal block offers fast oscillator, postscaled output and slow source
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pmcs_top
	import pmcs_pkg::*;
#(
	parameter int ADDR_W = PMCS_ADDR_W,
	parameter int GAP = PMCS_GAP_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic halt_exec,
	input wire logic wake_event,
	input wire logic primary_ready,
	input wire logic secondary_running,
	input wire logic internal_running,
	output logic [2:0] clock_source_onehot,
	output logic [2:0] internal_tap,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic primary_osc_en,
	output logic secondary_osc_enable,
	output logic secondary_clock_active,
	output logic primary_start_done
);
	typedef struct packed {
		logic idle_on_halt;
		logic [PMCS_SEL_W-1:0] clock_source_select;
		logic [PMCS_IFRQ_W-1:0] ifrq;
		logic [2:0] tap;
		logic sec_osc_en;
		logic sec_active;
		logic pri_done;
		pmcs_mode_t mode;
		pmcs_src_t cur;
		pmcs_src_t req_sel;
		logic mux_req;
		logic aw_got;
		logic [ADDR_W-1:0] waddr;
		logic w_got;
		logic [7:0] wbyte;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pmcs_state_t;

	pmcs_state_t s;
	pmcs_state_t next_s;
	pmcs_src_t mux_sel;
	pmcs_src_t target;
	logic mux_busy;
	logic mux_done;
	logic tgt_run;
	logic withhold;
	logic wr_do;
	logic [PMCS_SEL_W-1:0] wr_sel;

	function automatic pmcs_src_t pmcs_decode_sel(input logic [PMCS_SEL_W-1:0] sel);
		if (sel == PMCS_SEL_PRI) begin
			return PMCS_SRC_PRI;
		end else if (sel == PMCS_SEL_SEC) begin
			return PMCS_SRC_SEC;
		end
		return PMCS_SRC_INT;
	endfunction : pmcs_decode_sel

	function automatic logic pmcs_known(input logic [ADDR_W-1:0] a);
		return a == ADDR_W'(PMCS_OFS_OSC_CTL) || a == ADDR_W'(PMCS_OFS_STATUS)
			|| a == ADDR_W'(PMCS_OFS_LPT_CTL);
	endfunction : pmcs_known

	pmcs_glitch_mux #(
		.N(3),
		.GAP(GAP)
	) u_mux (
		.aclk(aclk),
		.aresetn(aresetn),
		.req(s.mux_req),
		.req_sel(s.req_sel),
		.sel_out(mux_sel),
		.busy(mux_busy),
		.done(mux_done)
	);

	////////////////////////////////////////////////////////////////////////
	// source choice and clock gating
	always_comb begin
		target = pmcs_decode_sel(s.clock_source_select);
		if (target == PMCS_SRC_SEC && !s.sec_osc_en) begin
			target = s.cur;
		end
		tgt_run = |(target & {internal_running, secondary_running, primary_ready});
		// enabled but silent secondary: stall rather than run on a dead clock
		withhold = target == PMCS_SRC_SEC && !secondary_running && s.cur != PMCS_SRC_SEC;
	end

	assign cpu_clk_en = s.mode == PMCS_ACTIVE && mux_sel != PMCS_SRC_NONE && !withhold;
	assign periph_clk_en = s.mode != PMCS_SLEEP && mux_sel != PMCS_SRC_NONE && !withhold;
	// primary stays on outside sleep unless settled in secondary run; it restarts once select leaves 01
	assign primary_osc_en = s.mode != PMCS_SLEEP
		&& !(s.cur == PMCS_SRC_SEC && target == PMCS_SRC_SEC);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_s = s;
		next_s.mux_req = 1'b0;
		wr_do = 1'b0;
		wr_sel = s.wbyte[PMCS_SEL_LSB +: PMCS_SEL_W];
		// primary not ready means no request, so the old source keeps clocking
		// cur lags mux_done by a cycle: asking then would repeat the same switch
		if (target != s.cur && tgt_run && !mux_busy && !mux_done && !s.mux_req) begin
			next_s.mux_req = 1'b1;
			next_s.req_sel = target;
		end
		if (mux_done) begin
			next_s.cur = mux_sel;
			if (mux_sel == PMCS_SRC_SEC) begin
				next_s.sec_active = 1'b1;
				next_s.pri_done = 1'b0;
			end else begin
				next_s.sec_active = 1'b0;
				if (mux_sel == PMCS_SRC_PRI) begin
					next_s.pri_done = 1'b1;
				end
			end
		end else if (s.cur == PMCS_SRC_PRI && primary_ready && !mux_busy) begin
			next_s.pri_done = 1'b1;
		end
		// internal tap follows its frequency field
		if (s.ifrq == PMCS_IFRQ_SLOW) begin
			next_s.tap = PMCS_TAP_SLOW;
		end else if (s.ifrq == PMCS_IFRQ_FAST) begin
			next_s.tap = PMCS_TAP_FAST;
		end else begin
			next_s.tap = PMCS_TAP_POST;
		end
		unique case (s.mode)
			PMCS_ACTIVE: begin
				if (halt_exec) begin
					// idle bit taken in the halt cycle
					next_s.mode = s.idle_on_halt ? PMCS_IDLE : PMCS_SLEEP;
				end
			end
			PMCS_IDLE, PMCS_SLEEP: begin
				if (wake_event) begin
					next_s.mode = PMCS_ACTIVE;
				end
			end
			default: begin
				next_s.mode = PMCS_ACTIVE;
			end
		endcase
		// axi4-lite write
		if (awvalid && awready) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = awaddr;
		end
		if (wvalid && wready) begin
			next_s.w_got = 1'b1;
			next_s.wbyte = wdata[7:0];
			next_s.wstb = wstrb[0];
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			wr_do = s.wstb;
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = pmcs_known(s.waddr) ? PMCS_RESP_OKAY : PMCS_RESP_SLVERR;
			if (wr_do && s.waddr == ADDR_W'(PMCS_OFS_OSC_CTL)) begin
				next_s.idle_on_halt = s.wbyte[PMCS_BIT_IDLE];
				next_s.clock_source_select = wr_sel;
				next_s.ifrq = s.wbyte[PMCS_IFRQ_LSB +: PMCS_IFRQ_W];
			end
			if (wr_do && s.waddr == ADDR_W'(PMCS_OFS_LPT_CTL)) begin
				next_s.sec_osc_en = s.wbyte[PMCS_BIT_SEC_OSC_EN];
			end
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		// axi4-lite read
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = '0;
			next_s.rresp = pmcs_known(araddr) ? PMCS_RESP_OKAY : PMCS_RESP_SLVERR;
			if (araddr == ADDR_W'(PMCS_OFS_OSC_CTL)) begin
				next_s.rdata[PMCS_BIT_IDLE] = s.idle_on_halt;
				next_s.rdata[PMCS_IFRQ_LSB +: PMCS_IFRQ_W] = s.ifrq;
				next_s.rdata[PMCS_SEL_LSB +: PMCS_SEL_W] = s.clock_source_select;
			end else if (araddr == ADDR_W'(PMCS_OFS_STATUS)) begin
				next_s.rdata[PMCS_ST_SEC_ACT] = s.sec_active;
				next_s.rdata[PMCS_ST_PRI_DONE] = s.pri_done;
				next_s.rdata[PMCS_ST_SRC_LSB +: 3] = s.cur;
				next_s.rdata[PMCS_ST_MODE_LSB +: 3] = s.mode;
			end else if (araddr == ADDR_W'(PMCS_OFS_LPT_CTL)) begin
				next_s.rdata[PMCS_BIT_SEC_ACTIVE] = s.sec_active;
				next_s.rdata[PMCS_BIT_SEC_OSC_EN] = s.sec_osc_en;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{
				idle_on_halt: 1'b0,
				clock_source_select: PMCS_SEL_RESET,
				ifrq: PMCS_IFRQ_RESET,
				tap: PMCS_TAP_SLOW,
				sec_osc_en: 1'b0,
				sec_active: 1'b0,
				pri_done: 1'b0,
				mode: PMCS_ACTIVE,
				cur: PMCS_SRC_RESET,
				req_sel: PMCS_SRC_RESET,
				mux_req: 1'b0,
				aw_got: 1'b0,
				waddr: '0,
				w_got: 1'b0,
				wbyte: 8'h00,
				wstb: 1'b0,
				bvalid: 1'b0,
				bresp: PMCS_RESP_OKAY,
				rvalid: 1'b0,
				rdata: 32'h0000_0000,
				rresp: PMCS_RESP_OKAY
			};
		end else begin
			s <= next_s;
		end
	end

	assign awready = !s.aw_got && !s.bvalid;
	assign wready = !s.w_got && !s.bvalid;
	assign arready = !s.rvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign clock_source_onehot = mux_sel;
	assign internal_tap = s.tap;
	assign secondary_osc_enable = s.sec_osc_en;
	assign secondary_clock_active = s.sec_active;
	assign primary_start_done = s.pri_done;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_sleep_no_clk: assert property (s.mode == PMCS_SLEEP |-> !cpu_clk_en && !periph_clk_en)
		else $error("clock running in sleep");
	chk_idle_cpu_off: assert property (s.mode == PMCS_IDLE |-> !cpu_clk_en)
		else $error("cpu clocked in idle");
	chk_halt_idle: assert property (
		s.mode == PMCS_ACTIVE && halt_exec && s.idle_on_halt |=> s.mode == PMCS_IDLE)
		else $error("halt with idle bit did not enter idle");
	chk_halt_sleep: assert property (
		s.mode == PMCS_ACTIVE && halt_exec && !s.idle_on_halt |=> s.mode == PMCS_SLEEP)
		else $error("halt without idle bit did not enter sleep");
	chk_halt_only: assert property (
		s.mode == PMCS_ACTIVE && !halt_exec |=> s.mode == PMCS_ACTIVE)
		else $error("power-managed mode entered without halt");
	chk_sec_flags: assert property (
		mux_done && mux_sel == PMCS_SRC_SEC |=> s.sec_active && !s.pri_done ##0 !primary_osc_en)
		else $error("secondary entry flags or primary shutdown wrong");
	chk_pri_flags: assert property (
		mux_done && mux_sel == PMCS_SRC_PRI |=> !s.sec_active && s.pri_done)
		else $error("primary return flags wrong");
	chk_sec_disabled: assert property (
		s.clock_source_select == PMCS_SEL_SEC && !s.sec_osc_en && s.cur != PMCS_SRC_SEC
		&& !mux_busy && !s.mux_req |=> !s.mux_req)
		else $error("secondary run entered with oscillator disabled");
	chk_withhold: assert property (withhold |-> !cpu_clk_en && !periph_clk_en)
		else $error("clocks given before secondary oscillator runs");
	chk_pri_wait: assert property (
		target == PMCS_SRC_PRI && !primary_ready && mux_sel == PMCS_SRC_SEC
		&& s.mode == PMCS_ACTIVE |-> cpu_clk_en && periph_clk_en && primary_osc_en)
		else $error("secondary clock dropped while primary starts");
	chk_switch_now: assert property (
		target != s.cur && tgt_run && !mux_busy && !mux_done && !s.mux_req
		|=> s.mux_req ##[1:8] mux_done)
		else $error("switch to running source not started at once");
	chk_no_resend: assert property (mux_done |=> !s.mux_req)
		else $error("finished switch requested again");
	chk_wake_keep: assert property (
		s.mode != PMCS_ACTIVE && wake_event && !wr_do |=>
		$stable(s.clock_source_select) && $stable(s.idle_on_halt) && $stable(s.sec_osc_en))
		else $error("wake-up changed control bits");
	chk_reg_write: assert property (
		wr_do && s.waddr == ADDR_W'(PMCS_OFS_OSC_CTL) |=> s.clock_source_select == $past(wr_sel))
		else $error("control register write lost");
	chk_tap_onehot: assert property ($onehot(s.tap))
		else $error("internal tap not one-hot");

	cov_idle: cover property (s.mode == PMCS_ACTIVE ##1 s.mode == PMCS_IDLE);
	cov_sleep_wake: cover property (s.mode == PMCS_SLEEP ##1 s.mode == PMCS_ACTIVE);
	cov_to_sec: cover property (mux_done && mux_sel == PMCS_SRC_SEC);
	cov_back_pri: cover property (s.cur == PMCS_SRC_SEC ##[1:200] mux_done && mux_sel == PMCS_SRC_PRI);
endmodule : pmcs_top
`default_nettype wire

/* testbench/tb.sv */
// Purpose: self-checking bench for the power mode and clock select block
// Assumes: oscillator status inputs driven by the bench, synchronous to aclk
// Notes: outputs sampled at the falling edge, inputs driven after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb
	import pmcs_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic halt_exec = 1'b0, wake_event = 1'b0;
	logic primary_ready = 1'b1, secondary_running = 1'b0, internal_running = 1'b1;
	logic [2:0] clock_source_onehot, internal_tap;
	logic cpu_clk_en, periph_clk_en, primary_osc_en;
	logic secondary_osc_enable, secondary_clock_active, primary_start_done;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	logic saw_gap;
	logic [31:0] rd;

	always #5 aclk = ~aclk;

	pmcs_top #(.ADDR_W(4), .GAP(2)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.halt_exec(halt_exec), .wake_event(wake_event),
		.primary_ready(primary_ready), .secondary_running(secondary_running),
		.internal_running(internal_running),
		.clock_source_onehot(clock_source_onehot), .internal_tap(internal_tap),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.primary_osc_en(primary_osc_en), .secondary_osc_enable(secondary_osc_enable),
		.secondary_clock_active(secondary_clock_active),
		.primary_start_done(primary_start_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] st(logic s, logic p, pmcs_src_t src, logic [2:0] m);
		return {24'h0, m, src, p, s};
	endfunction : st

	////////////////////////////////////////////////////////////////////////////////
	// handshakes judged at the falling edge, where ready and valid are settled
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		aw = 1'b0;
		w = 1'b0;
		b = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			if (awvalid && awready) aw = 1'b1;
			if (wvalid && wready) w = 1'b1;
			b = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
		check("bresp", 32'(r), 32'(er));
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ar, r;
		logic [1:0] rr;
		ar = 1'b0;
		r = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r) begin
			@(negedge aclk);
			if (arvalid && arready) ar = 1'b1;
			r = rvalid && rready;
			d = rdata;
			rr = rresp;
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
			if (r) rready <= 1'b0;
		end
		check("rresp", 32'(rr), 32'(er));
	endtask : axi_rd

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] v;
		axi_rd(a, PMCS_RESP_OKAY, v);
		check("register", v, e);
	endtask : rd_chk

	task automatic wait_src(input pmcs_src_t e);
		int n;
		n = 0;
		@(negedge aclk);
		while (clock_source_onehot !== e && n < 40) begin
			if (clock_source_onehot === PMCS_SRC_NONE) saw_gap = 1'b1;
			@(negedge aclk);
			n++;
		end
		check("source", 32'(clock_source_onehot), 32'(e));
		repeat (3) @(negedge aclk);
	endtask : wait_src

	task automatic pulse(input logic halt);
		@(posedge aclk);
		if (halt) halt_exec <= 1'b1;
		else wake_event <= 1'b1;
		@(posedge aclk);
		halt_exec <= 1'b0;
		wake_event <= 1'b0;
		@(negedge aclk);
	endtask : pulse

	task automatic enables(input logic cpu, input logic per);
		check("cpu_clk_en", 32'(cpu_clk_en), 32'(cpu));
		check("periph_clk_en", 32'(periph_clk_en), 32'(per));
	endtask : enables

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// reset state and map
		rd_chk(PMCS_OFS_OSC_CTL, 32'h0);
		rd_chk(PMCS_OFS_STATUS, st(1'b0, 1'b1, PMCS_SRC_PRI, PMCS_ACTIVE));
		rd_chk(PMCS_OFS_LPT_CTL, 32'h0);
		axi_rd(4'hc, PMCS_RESP_SLVERR, rd);
		axi_wr(4'hc, 32'hff, PMCS_RESP_SLVERR);
		axi_wr(PMCS_OFS_STATUS, 32'hff, PMCS_RESP_OKAY);
		rd_chk(PMCS_OFS_STATUS, st(1'b0, 1'b1, PMCS_SRC_PRI, PMCS_ACTIVE));
		check("tap", 32'(internal_tap), 32'(PMCS_TAP_SLOW));
		enables(1'b1, 1'b1);
		// secondary requested while its oscillator is disabled
		axi_wr(PMCS_OFS_OSC_CTL, 32'h01, PMCS_RESP_OKAY);
		repeat (10) @(negedge aclk);
		check("source", 32'(clock_source_onehot), 32'(PMCS_SRC_PRI));
		enables(1'b1, 1'b1);
		axi_wr(PMCS_OFS_OSC_CTL, 32'h00, PMCS_RESP_OKAY);
		// enabled but not yet running: clocks withheld
		axi_wr(PMCS_OFS_LPT_CTL, 32'h08, PMCS_RESP_OKAY);
		check("sec_osc_en", 32'(secondary_osc_enable), 32'h1);
		axi_wr(PMCS_OFS_OSC_CTL, 32'h01, PMCS_RESP_OKAY);
		repeat (10) @(negedge aclk);
		enables(1'b0, 1'b0);
		saw_gap = 1'b0;
		@(posedge aclk);
		secondary_running <= 1'b1;
		wait_src(PMCS_SRC_SEC);
		check("gap", 32'(saw_gap), 32'h1);
		check("sec_active", 32'(secondary_clock_active), 32'h1);
		check("pri_done", 32'(primary_start_done), 32'h0);
		check("pri_osc_en", 32'(primary_osc_en), 32'h0);
		enables(1'b1, 1'b1);
		rd_chk(PMCS_OFS_STATUS, st(1'b1, 1'b0, PMCS_SRC_SEC, PMCS_ACTIVE));
		rd_chk(PMCS_OFS_LPT_CTL, 32'h48);
		// idle on halt; idle bit cleared while idle must not matter
		axi_wr(PMCS_OFS_OSC_CTL, 32'h81, PMCS_RESP_OKAY);
		@(negedge aclk);
		enables(1'b1, 1'b1);
		pulse(1'b1);
		@(negedge aclk);
		enables(1'b0, 1'b1);
		axi_wr(PMCS_OFS_OSC_CTL, 32'h01, PMCS_RESP_OKAY);
		@(negedge aclk);
		enables(1'b0, 1'b1);
		rd_chk(PMCS_OFS_STATUS, st(1'b1, 1'b0, PMCS_SRC_SEC, PMCS_IDLE));
		pulse(1'b0);
		@(negedge aclk);
		enables(1'b1, 1'b1);
		rd_chk(PMCS_OFS_OSC_CTL, 32'h01);
		check("sec_osc_en", 32'(secondary_osc_enable), 32'h1);
		// sleep with idle bit clear
		pulse(1'b1);
		@(negedge aclk);
		enables(1'b0, 1'b0);
		rd_chk(PMCS_OFS_STATUS, st(1'b1, 1'b0, PMCS_SRC_SEC, PMCS_SLEEP));
		pulse(1'b0);
		@(negedge aclk);
		enables(1'b1, 1'b1);
		// back to primary: secondary keeps clocking until primary is ready
		@(posedge aclk);
		primary_ready <= 1'b0;
		axi_wr(PMCS_OFS_OSC_CTL, 32'h00, PMCS_RESP_OKAY);
		repeat (10) @(negedge aclk);
		check("source", 32'(clock_source_onehot), 32'(PMCS_SRC_SEC));
		check("pri_osc_en", 32'(primary_osc_en), 32'h1);
		enables(1'b1, 1'b1);
		@(posedge aclk);
		primary_ready <= 1'b1;
		wait_src(PMCS_SRC_PRI);
		check("sec_active", 32'(secondary_clock_active), 32'h0);
		check("pri_done", 32'(primary_start_done), 32'h1);
		rd_chk(PMCS_OFS_STATUS, st(1'b0, 1'b1, PMCS_SRC_PRI, PMCS_ACTIVE));
		// internal block: both internal codes and all three taps
		axi_wr(PMCS_OFS_OSC_CTL, 32'h72, PMCS_RESP_OKAY);
		wait_src(PMCS_SRC_INT);
		check("tap", 32'(internal_tap), 32'(PMCS_TAP_FAST));
		enables(1'b1, 1'b1);
		axi_wr(PMCS_OFS_OSC_CTL, 32'h33, PMCS_RESP_OKAY);
		repeat (4) @(negedge aclk);
		check("tap", 32'(internal_tap), 32'(PMCS_TAP_POST));
		check("source", 32'(clock_source_onehot), 32'(PMCS_SRC_INT));
		axi_wr(PMCS_OFS_OSC_CTL, 32'h02, PMCS_RESP_OKAY);
		repeat (4) @(negedge aclk);
		check("tap", 32'(internal_tap), 32'(PMCS_TAP_SLOW));
		axi_wr(PMCS_OFS_OSC_CTL, 32'h00, PMCS_RESP_OKAY);
		wait_src(PMCS_SRC_PRI);
		// secondary already oscillating before it is chosen: no withholding, one clean switch
		axi_wr(PMCS_OFS_OSC_CTL, 32'h01, PMCS_RESP_OKAY);
		@(negedge aclk);
		enables(1'b1, 1'b1);
		wait_src(PMCS_SRC_SEC);
		enables(1'b1, 1'b1);
		check("sec_active", 32'(secondary_clock_active), 32'h1);
		conclude();
	end
endmodule : tb
`default_nettype wire
